// File: hw/tbm_pkg.sv
// Package with constants, register map and types of the token bucket meter
//
// Overview of operation
// - Reset fills bucket; idle full bucket stays.
// - Refill by elapsed ticks times rate, capped.
// - Full bucket banks no further credit.
// - Strict: conform if occupancy minus length nonnegative.
// - Strict reject leaves refilled occupancy untouched.
// - Full bucket accepts any length up to size.
// - Loose: negative count rejects every packet.
// - Burst size may be as small as one.
// - Shaper eligibility is later of arrival, accrual; arrival when rate is zero.
// - Loose: positive occupancy accepts, may go negative.
// - Refill adds to occupancy, even negative.
package tbm_pkg;

   // ------------------------------------------------------------
   // Widths
   // ------------------------------------------------------------
   localparam int unsigned LEN_W = 16;
   localparam int unsigned SIZE_W = 24;
   localparam int unsigned RATE_W = 16;
   localparam int unsigned TIME_W = 32;
   localparam int unsigned OCC_W = 26;

   // ------------------------------------------------------------
   // Register map (word addresses)
   // ------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_SIZE = 4'h1;
   localparam logic [ADDR_W-1:0] REG_RATE = 4'h2;
   localparam logic [ADDR_W-1:0] REG_OCC = 4'h3;
   localparam logic [ADDR_W-1:0] REG_TIME = 4'h4;
   localparam logic [ADDR_W-1:0] REG_CNT_OK = 4'h5;
   localparam logic [ADDR_W-1:0] REG_CNT_NOK = 4'h6;

   // Field positions, reset values and minimum size
   localparam int unsigned CTRL_LOOSE_BIT = 0;
   localparam int unsigned CTRL_RELOAD_BIT = 1;
   localparam logic [SIZE_W-1:0] SIZE_RST = 24'h003000;
   localparam logic [RATE_W-1:0] RATE_RST = 16'h0001;
   localparam logic [SIZE_W-1:0] SIZE_MIN = 24'h000001;

   typedef enum logic {MODE_STRICT, MODE_LOOSE} mode_t;

endpackage

// File: hw/token_bucket_meter.sv
// Two-parameter token bucket meter with strict and loose conformance
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps
module token_bucket_meter (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic pkt_valid_i,
   input wire logic [tbm_pkg::LEN_W-1:0] pkt_len_i,
   output logic verdict_valid_o,
   output logic conform_o,
   output logic [tbm_pkg::TIME_W-1:0] eligible_time_o,
   output logic [tbm_pkg::TIME_W-1:0] now_o,
   input wire logic [tbm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o
);
   import tbm_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      mode_t mode;
      logic [SIZE_W-1:0] size;
      logic [RATE_W-1:0] rate;
      logic signed [OCC_W-1:0] occ;
      logic [TIME_W-1:0] now;
      logic [TIME_W-1:0] last;
      logic verdict_valid;
      logic conform;
      logic [TIME_W-1:0] elig;
      logic [31:0] cnt_ok;
      logic [31:0] cnt_nok;
      logic [31:0] rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   // Wide enough that ticks times rate never wraps before the cap
   localparam int unsigned PROD_W = TIME_W + RATE_W + 1;

   logic [TIME_W-1:0] delta;
   logic [PROD_W-1:0] credit;
   logic signed [PROD_W:0] sum;
   logic signed [OCC_W-1:0] refill;
   logic signed [OCC_W-1:0] after;
   logic signed [OCC_W-1:0] lenx;
   logic signed [OCC_W-1:0] sizex;
   logic ok;
   logic [SIZE_W-1:0] wsize;
   logic [PROD_W-1:0] need;
   logic [PROD_W-1:0] wait_t;
   logic [TIME_W-1:0] t_full;

   always_comb begin
      s_d = s_q;
      delta = s_q.now - s_q.last;
      credit = PROD_W'(delta) * PROD_W'(s_q.rate);
      lenx = OCC_W'($signed({1'b0, pkt_len_i}));
      sizex = OCC_W'($signed({1'b0, s_q.size}));
      // Adds to occupancy even when negative, never jumps to full
      sum = (PROD_W+1)'(s_q.occ) + $signed({1'b0, credit});
      // Cap means time spent full earns nothing extra
      if (sum > (PROD_W+1)'(sizex)) begin
         refill = sizex;
      end else begin
         refill = OCC_W'(sum);
      end
      // Strict needs every bit covered; loose needs any token left
      if (s_q.mode == MODE_STRICT) begin
         ok = (refill - lenx) >= 0;
      end else begin
         ok = refill > 0;
      end
      after = ok ? (refill - lenx) : refill;
      // Shaper: time at which the packet length has accrued, or now if rate is zero
      need = (lenx > refill) ? PROD_W'(lenx - refill) : '0;
      if (s_q.rate == '0) begin
         wait_t = '0;
      end else begin
         wait_t = (need + PROD_W'(s_q.rate) - 1) / PROD_W'(s_q.rate);
      end
      t_full = s_q.now + TIME_W'(wait_t);
      s_d.now = s_q.now + 1'b1;
      s_d.verdict_valid = pkt_valid_i;
      // ----------------------------------------------------------
      // Packet judgement
      // ----------------------------------------------------------
      if (pkt_valid_i) begin
         s_d.occ = after;
         s_d.last = s_q.now;
         s_d.conform = ok;
         s_d.elig = t_full;
         if (ok) begin
            s_d.cnt_ok = s_q.cnt_ok + 1'b1;
         end else begin
            s_d.cnt_nok = s_q.cnt_nok + 1'b1;
         end
      end
      // ----------------------------------------------------------
      // Register port
      // ----------------------------------------------------------
      wsize = wdata_i[SIZE_W-1:0];
      if (wsize < SIZE_MIN) begin
         wsize = SIZE_MIN;
      end
      if (wr_i) begin
         case (addr_i)
            REG_CTRL: begin
               s_d.mode = wdata_i[CTRL_LOOSE_BIT] ? MODE_LOOSE : MODE_STRICT;
               if (wdata_i[CTRL_RELOAD_BIT]) begin
                  s_d.occ = sizex;
                  s_d.last = s_q.now;
               end
            end
            REG_SIZE: begin
               s_d.size = wsize;
               // Shrinking size clips stored credit to the new cap
               if (s_d.occ > OCC_W'($signed({1'b0, wsize}))) begin
                  s_d.occ = OCC_W'($signed({1'b0, wsize}));
               end
            end
            REG_RATE: begin
               s_d.rate = wdata_i[RATE_W-1:0];
            end
            default: begin
            end
         endcase
      end
      s_d.rdata = '0;
      if (rd_i) begin
         case (addr_i)
            REG_CTRL: s_d.rdata = {30'h0, 1'b0, s_q.mode == MODE_LOOSE};
            REG_SIZE: s_d.rdata = 32'(s_q.size);
            REG_RATE: s_d.rdata = 32'(s_q.rate);
            REG_OCC: s_d.rdata = 32'(refill);
            REG_TIME: s_d.rdata = s_q.now;
            REG_CNT_OK: s_d.rdata = s_q.cnt_ok;
            REG_CNT_NOK: s_d.rdata = s_q.cnt_nok;
            default: s_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q.mode <= MODE_STRICT;
         s_q.size <= SIZE_RST;
         s_q.rate <= RATE_RST;
         s_q.occ <= OCC_W'($signed({1'b0, SIZE_RST}));
         s_q.now <= '0;
         s_q.last <= '0;
         s_q.verdict_valid <= 1'b0;
         s_q.conform <= 1'b0;
         s_q.elig <= '0;
         s_q.cnt_ok <= '0;
         s_q.cnt_nok <= '0;
         s_q.rdata <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign verdict_valid_o = s_q.verdict_valid;
   assign conform_o = s_q.conform;
   assign eligible_time_o = s_q.elig;
   assign now_o = s_q.now;
   assign rdata_o = s_q.rdata;

endmodule

// File: tb/pkt_src.sv
// Upstream packet source model
`timescale 1ns/100ps
module pkt_src (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [tbm_pkg::LEN_W-1:0] len_i,
   output logic pkt_valid_o = 1'b0,
   output logic [tbm_pkg::LEN_W-1:0] pkt_len_o = 16'h0
);
   import tbm_pkg::*;
   // Length is scrambled between packets so a stale value never looks valid
   always @(posedge clk_i) begin
      pkt_valid_o <= go_i;
      pkt_len_o <= go_i ? len_i : ~pkt_len_o;
   end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the token bucket meter
`timescale 1ns/100ps
module tb_top;
   import tbm_pkg::*;
   logic clk_i = 1'b0, rstn_i = 1'b0, go = 1'b0, wr = 1'b0, rd = 1'b0, pv, vv, cf;
   logic [15:0] gl = 16'h0, pl;
   logic [3:0] ad = 4'h0;
   logic [31:0] wd = 32'h0, rdata, et, nw;
   int num_errors = 0, n_checks = 0, tick = 0, seed = 32'hb819, last = 0, t, n_ok = 0, n_nok = 0;
   longint occ = 24'h3000, size = 24'h3000, rate = 1, loose = 0;
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) tick <= tick + 1;
   pkt_src SRC (.clk_i, .go_i(go), .len_i(gl), .pkt_valid_o(pv), .pkt_len_o(pl));
   token_bucket_meter DUT (.clk_i, .rstn_i, .pkt_valid_i(pv), .pkt_len_i(pl), .verdict_valid_o(vv), .conform_o(cf),
      .eligible_time_o(et), .now_o(nw), .addr_i(ad), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdata));
   // Lump refill at event time; equal to per-tick accrual while rate is fixed
   function automatic longint refill(int at);
      longint r;
      r = occ + longint'(at - last) * rate;
      return (r > size) ? size : r;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      ad <= a;
      wd <= d;
      wr <= 1'b1;
      t = tick;
      @(posedge clk_i);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk_i);
      ad <= a;
      rd <= 1'b1;
      t = tick;
      @(posedge clk_i);
      rd <= 1'b0;
      #1 chk(rdata, (a == REG_OCC) ? 32'(refill(t)) : e);
   endtask
   task automatic pkt(input logic [15:0] l);
      longint r, w, ll;
      bit ok;
      // Signed copy of the length: mixing it unsigned would make every test unsigned
      ll = l;
      @(posedge clk_i);
      go <= 1'b1;
      gl <= l;
      @(posedge clk_i);
      go <= 1'b0;
      t = tick;
      r = refill(t);
      ok = (loose != 0) ? (r > 0) : (r - ll >= 0);
      w = (ll > r && rate != 0) ? (ll - r + rate - 1) / rate : 0;
      if (ok) n_ok++;
      else n_nok++;
      @(posedge clk_i);
      #1 chk(vv, 1'b1);
      chk(cf, ok);
      chk(et, nw - 32'h1 + 32'(w));
      occ = ok ? r - ll : r;
      last = t;
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      rchk(REG_OCC, 0);
      repeat (40) @(posedge clk_i);
      rchk(REG_OCC, 0);
      rchk(4'hf, 32'h0);
      wreg(REG_RATE, 32'h40);
      rate = 64;
      for (int i = 0; i < 300; i++) begin
         if (i == 150) begin
            wreg(REG_CTRL, 32'h1);
            loose = 1;
            pkt(16'hffff);
            pkt(16'h0001);
         end
         repeat ($unsigned($random(seed)) % 200) @(posedge clk_i);
         pkt(16'($unsigned($random(seed)) % 32'h3000));
      end
      wreg(REG_RATE, 32'h0);
      rate = 0;
      wreg(REG_CTRL, 32'h2);
      loose = 0;
      occ = size;
      last = t;
      pkt(16'h3000);
      pkt(16'h0001);
      rchk(REG_OCC, 0);
      wreg(REG_SIZE, 32'h0);
      rchk(REG_SIZE, 32'h1);
      rchk(REG_CNT_OK, 32'(n_ok));
      rchk(REG_CNT_NOK, 32'(n_nok));
      final_report;
   end
endmodule

// File: tb/tbm_sva.sv
// Port checker for the token bucket meter
`timescale 1ns/100ps
module tbm_sva (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic pkt_valid_i,
   input wire logic [tbm_pkg::LEN_W-1:0] pkt_len_i,
   input wire logic verdict_valid_o,
   input wire logic conform_o,
   input wire logic [tbm_pkg::TIME_W-1:0] eligible_time_o,
   input wire logic [tbm_pkg::TIME_W-1:0] now_o,
   input wire logic [tbm_pkg::ADDR_W-1:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [31:0] rdata_o
);
   import tbm_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_verdict_next: assert property (pkt_valid_i |=> verdict_valid_o) else $error("late");
   a_verdict_only: assert property (!pkt_valid_i |=> !verdict_valid_o) else $error("stray");
   a_conform_hold: assert property (!verdict_valid_o |-> $stable(conform_o)) else $error("cf");
   a_elig_hold: assert property (!verdict_valid_o |-> $stable(eligible_time_o)) else $error("et");
   a_elig_early: assert property (verdict_valid_o |-> eligible_time_o >= $past(now_o)) else $error("early");
   a_tick_step: assert property ($past(rstn_i) |-> now_o == $past(now_o) + 32'h1) else $error("tick");
   a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("rd");
   a_time_read: assert property (rd_i && addr_i == REG_TIME |=> rdata_o == $past(now_o)) else $error("tm");
endmodule
bind token_bucket_meter tbm_sva chk (.clk_i, .rstn_i, .pkt_valid_i, .pkt_len_i, .verdict_valid_o, .conform_o,
   .eligible_time_o, .now_o, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
